// ==== core/rbs_defines.svh ====
// Constants for the reset and brown-out sequencer
//
// Contract
// (R1) Hold core reset while power-on detector says supply is too low.
// (R2) Enabled power-up timer gives a nominal 64 ms delay after POR/BOR.
// (R3) Core stays in reset while the power-up timer counts.
// (R4) Power-up timer is enabled by a cleared, active-low config bit.
// (R5) Power-up timer starts only after POR and BOR are both released.
// (R6) Mode field: 11 on, 10 off in sleep, 01 software, 00 off.
// (R7) One config bit selects the brown-out trip level.
// (R8) Brown-out trips only on dips longer than the filter time.
// (R9) Mode 11: start waits ready and supply; sleep protected; no wake delay.
// (R10) Mode 10: no protection in sleep; wake waits for detector ready.
// (R11) Mode 01: software bit gates detector; start does not wait.
// (R12) Software mode: protection once ready; ready bit shows detector.
// (R13) Software mode: sleep does not change protection.
// (R14) Forced-on modes: ready is set before the core may run.
// (R15) Software enable acts only in mode 01; elsewhere stored only.
// (R16) Fast start keeps band gap on in modes 10 and 01 only.
// (R17) Read-only ready bit is 1 while the brown-out circuit is active.
// (R18) Combiner takes POR, BOR, LP-BOR, pin, WDT, instr, stack, prog exit.
// (R19) Timer expired with pin low: run 10 clocks after pin rises.
// (R20) Run only after timer done (if enabled) and pin released.
// (R21) Core reset asserts at once, releases on the system clock; code asserts at once only on POR, on the clock for other sources.
// (R22) Enable resets to 1, fast start to 0, on POR and BOR only; code also resets them on LP-BOR and prog exit.
`ifndef RBS_DEFINES_SVH
`define RBS_DEFINES_SVH

`define RBS_CLK_KHZ          250000
`define RBS_POWERUP_DELAY_TIMER_TIME_MS     64
`define RBS_POWERUP_DELAY_TIMER_CYCLES      (`RBS_POWERUP_DELAY_TIMER_TIME_MS * `RBS_CLK_KHZ)
`define RBS_DIP_TIME_NS      1000
`define RBS_DIP_CYCLES       (`RBS_DIP_TIME_NS * `RBS_CLK_KHZ / 1000000)
`define RBS_START_DLY_CYC    4'd10

`define RBS_ADDR_W           12
`define RBS_OFS_CONTROL      12'h000
`define RBS_OFS_STATUS       12'h004

`define RBS_BIT_SW_EN        7
`define RBS_BIT_FAST_START   6
`define RBS_BIT_READY        0
`define RBS_RST_SW_EN        1'b1
`define RBS_RST_FAST_START   1'b0

`endif

// ==== core/rbs_pkg.sv ====
// Types shared by the reset and brown-out sequencer
package rbs_pkg;

  typedef enum logic [1:0] {
    RBS_MODE_OFF   = 2'b00,
    RBS_MODE_SW    = 2'b01,
    RBS_MODE_SLEEP = 2'b10,
    RBS_MODE_ON    = 2'b11
  } rbs_mode_e;

  typedef enum logic [2:0] {
    RBS_ST_HOLD  = 3'b000,
    RBS_ST_START = 3'b001,
    RBS_ST_PIN   = 3'b010,
    RBS_ST_DELAY = 3'b011,
    RBS_ST_SOFT  = 3'b100,
    RBS_ST_RUN   = 3'b101
  } rbs_state_e;

endpackage

// ==== core/rbs_dip_filter.sv ====
// Brown-out dip filter: trips only on sustained undervoltage
`timescale 1ns/1ns
`default_nettype none
`include "rbs_defines.svh"
module rbs_dip_filter (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Comparator
  input  wire logic armed,
  input  wire logic below,
  // Result
  output logic      trip_q
);
  localparam int unsigned DIP_CYC = `RBS_DIP_CYCLES;
  logic [11:0] cnt_q;

  // Counter saturates so a long dip holds the trip without wrapping
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 12'h000;
    end else if (!armed || !below) begin
      cnt_q <= 12'h000;
    end else if (cnt_q != DIP_CYC[11:0]) begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  // Trip needs a dip longer than the filter time [R8]
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= armed && below && (cnt_q == DIP_CYC[11:0]);
    end
  end
endmodule
`default_nettype wire

// ==== core/rbs_sequencer.sv ====
// Reset combiner, power-up timer and brown-out control with APB access
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "rbs_defines.svh"
module rbs_sequencer #(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = `RBS_POWERUP_DELAY_TIMER_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  // Supply detectors
  input  wire logic                   por_vdd_low,
  input  wire logic                   bor_vdd_low,
  input  wire logic                   bor_det_ready,
  input  wire logic                   low_power_brownout_reset_vdd_low,
  // Configuration bits
  input  wire rbs_pkg::rbs_mode_e     brownout_mode_sel,
  input  wire logic                   brownout_level_sel,
  input  wire logic                   powerup_delay_enable_n,
  input  wire logic                   low_power_brownout_reset_cfg_en,
  input  wire logic                   ext_reset_cfg_en,
  input  wire logic                   stack_reset_cfg_en,
  // Other reset sources
  input  wire logic                   external_reset_pin_n,
  input  wire logic                   wdt_reset_req,
  input  wire logic                   instr_reset_req,
  input  wire logic                   stack_overflow_req,
  input  wire logic                   stack_underflow_req,
  input  wire logic                   prog_mode_exit,
  // Core power state
  input  wire logic                   core_sleep,
  input  wire logic                   wake_req,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`RBS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Core and analog controls
  output logic                        core_rst_n,
  output logic                        wake_grant,
  output logic                        bor_detector_en,
  output logic                        bandgap_force_on,
  output logic                        brownout_level
);
  import rbs_pkg::*;

  rbs_state_e  state_q;
  rbs_state_e  state_d;
  logic        sw_brownout_enable_q;
  logic        brownout_fast_start_q;
  logic        brownout_ready_q;
  logic [23:0] powerup_delay_timer_cnt_q;
  logic        powerup_delay_timer_done;
  logic [3:0]  dly_cnt_q;
  logic        det_en;
  logic        prot_active;
  logic        bor_trip;
  logic        low_power_brownout_reset_hit;
  logic        supply_event;
  logic        soft_event;
  logic        pin_held;
  logic        start_ok;
  logic        hard_rst_b;
  logic        apb_done;
  logic        apb_setup;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        ctrl_wr;
  logic        timer_clear;
  logic        dly_last;
  logic        wake_ok;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  // Detector enable per mode [R6]
  function automatic logic det_on(input rbs_mode_e m,
                                  input logic sleep,
                                  input logic sw_en);
    case (m)
      RBS_MODE_ON:    det_on = 1'b1;          // [R9]
      RBS_MODE_SLEEP: det_on = !sleep;        // [R10]
      RBS_MODE_SW:    det_on = sw_en;         // [R11] [R13] [R15]
      default:        det_on = 1'b0;
    endcase
  endfunction

  // Modes in which hardware forces the detector on
  function automatic logic hw_forced(input rbs_mode_e m);
    hw_forced = (m == RBS_MODE_ON) || (m == RBS_MODE_SLEEP);
  endfunction

  // Modes in which the fast-start bit may hold the band gap up
  function automatic logic fast_start_mode(input rbs_mode_e m);
    fast_start_mode = (m == RBS_MODE_SLEEP) || (m == RBS_MODE_SW);
  endfunction

  assign det_en      = det_on(brownout_mode_sel, core_sleep,
                              sw_brownout_enable_q);
  assign prot_active = det_en && bor_det_ready;     // [R12]

  // Filtered brown-out event
  rbs_dip_filter u_dip (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .armed   (prot_active),
    .below   (bor_vdd_low),
    .trip_q  (bor_trip)
  );

  // Low-power detector covers the off and sleep-off cases
  assign low_power_brownout_reset_hit = low_power_brownout_reset_cfg_en && low_power_brownout_reset_vdd_low;

  // Events that behave like a power-on reset [R18]
  assign supply_event = por_vdd_low || bor_trip || low_power_brownout_reset_hit
                        || prog_mode_exit;

  // Events that only restart the core [R18]
  assign soft_event = wdt_reset_req || instr_reset_req
                      || (stack_reset_cfg_en
                          && (stack_overflow_req
                              || stack_underflow_req));

  assign pin_held = ext_reset_cfg_en && !external_reset_pin_n;

  // Timer bypass when the active-low enable is high [R4]
  assign powerup_delay_timer_done = powerup_delay_enable_n
                     || (powerup_delay_timer_cnt_q == POWERUP_DELAY_TIMER_CYCLES[23:0]);

  // Forced-on modes wait for ready and good supply [R9] [R10] [R14]
  assign start_ok = powerup_delay_timer_done
                    && (!hw_forced(brownout_mode_sel)
                        || (bor_det_ready && !bor_vdd_low)); // [R11]

  // Power-on detector pulls the core reset without a clock [R1] [R21]
  assign hard_rst_b = rst_b && !por_vdd_low;

  // Timer restarts on every supply event, never on soft resets [R5]
  assign timer_clear = (state_q == RBS_ST_HOLD) || supply_event;

  // Last cycle of the start delay after the pin rises [R19]
  assign dly_last = (dly_cnt_q == `RBS_START_DLY_CYC - 4'd1);

  // Power-up timer, cleared while a supply event is present [R5]
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      powerup_delay_timer_cnt_q <= 24'h000000;
    end else if (timer_clear) begin
      powerup_delay_timer_cnt_q <= 24'h000000;                   // [R5]
    end else if (!powerup_delay_timer_done) begin
      powerup_delay_timer_cnt_q <= powerup_delay_timer_cnt_q + 24'h000001;      // [R2]
    end
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      RBS_ST_HOLD: begin
        if (!supply_event) begin
          state_d = RBS_ST_START;                 // [R5]
        end
      end
      RBS_ST_START: begin
        // Timer runs regardless of the pin [R3] [R20]
        if (start_ok) begin
          state_d = pin_held ? RBS_ST_PIN : RBS_ST_RUN;
        end
      end
      RBS_ST_PIN: begin
        if (!pin_held) begin
          state_d = RBS_ST_DELAY;                 // [R19]
        end
      end
      RBS_ST_DELAY: begin
        if (pin_held) begin
          state_d = RBS_ST_PIN;
        end else if (dly_last) begin
          state_d = RBS_ST_RUN;                   // [R19]
        end
      end
      RBS_ST_SOFT: begin
        state_d = pin_held ? RBS_ST_PIN : RBS_ST_RUN;
      end
      RBS_ST_RUN: begin
        if (pin_held) begin
          state_d = RBS_ST_PIN;                   // [R20]
        end else if (soft_event) begin
          state_d = RBS_ST_SOFT;                  // [R18]
        end
      end
      default: begin
        state_d = RBS_ST_HOLD;
      end
    endcase
    // Supply events win from any state [R1]
    if (supply_event) begin
      state_d = RBS_ST_HOLD;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= RBS_ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // Start delay after the pin rises
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dly_cnt_q <= 4'h0;
    end else if (state_q == RBS_ST_DELAY) begin
      dly_cnt_q <= dly_cnt_q + 4'h1;
    end else begin
      dly_cnt_q <= 4'h0;
    end
  end

  // Core reset: async assert on POR, clocked assert for other sources, clocked release [R21] [R3]
  always_ff @(posedge clk_sys or negedge hard_rst_b) begin
    if (!hard_rst_b) begin
      core_rst_n <= 1'b0;                         // [R1]
    end else begin
      core_rst_n <= (state_d == RBS_ST_RUN);      // [R21]
    end
  end

  // Sleep-off mode wakes only on a ready detector
  assign wake_ok = core_sleep && wake_req
                   && (brownout_mode_sel != RBS_MODE_SLEEP
                       || bor_det_ready);         // [R9] [R10]

  // Wake from sleep, one cycle after the request
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wake_grant <= 1'b0;
    end else begin
      wake_grant <= wake_ok;                      // [R10]
    end
  end

  // Detector enable, one cycle after mode or sleep moves
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bor_detector_en <= 1'b0;
    end else begin
      bor_detector_en <= det_en;                  // [R6]
    end
  end

  // Band gap hold; fixed modes ignore the fast-start bit
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bandgap_force_on <= 1'b0;
    end else begin
      bandgap_force_on <= brownout_fast_start_q
                          && fast_start_mode(brownout_mode_sel); // [R16]
    end
  end

  // Trip level is a straight copy of its configuration bit
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      brownout_level <= 1'b0;
    end else begin
      brownout_level <= brownout_level_sel;       // [R7]
    end
  end

  // Ready status follows the detector [R17]
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      brownout_ready_q <= 1'b0;
    end else begin
      brownout_ready_q <= prot_active;           // [R12] [R17]
    end
  end

  // APB decode; no wait states, ready in the first access cycle
  assign apb_setup = psel && !penable && !pready;
  assign apb_done  = psel && penable && pready;
  assign hit_ctrl  = (paddr == `RBS_OFS_CONTROL);
  assign hit_stat  = (paddr == `RBS_OFS_STATUS);
  assign ctrl_wr   = apb_done && pwrite && hit_ctrl;

  // Register images; unused bits read as zero
  assign ctrl_word = {24'h000000,
                      sw_brownout_enable_q,
                      brownout_fast_start_q,
                      5'h00,
                      brownout_ready_q};
  assign stat_word = {24'h000000,
                      1'b0,
                      state_q,
                      powerup_delay_timer_done,
                      bor_trip,
                      det_en,
                      core_rst_n};

  // Control bits; supply reset beats a software write [R22]
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sw_brownout_enable_q  <= `RBS_RST_SW_EN;
      brownout_fast_start_q <= `RBS_RST_FAST_START;
    end else if (supply_event) begin
      sw_brownout_enable_q  <= `RBS_RST_SW_EN;      // [R22]
      brownout_fast_start_q <= `RBS_RST_FAST_START; // [R22]
    end else if (ctrl_wr) begin
      sw_brownout_enable_q  <= pwdata[`RBS_BIT_SW_EN];      // [R15]
      brownout_fast_start_q <= pwdata[`RBS_BIT_FAST_START];
    end
  end

  // Ready strobe: high for the access phase only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_setup;
    end
  end

  // Error flags an unmapped address
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= apb_setup && !hit_ctrl && !hit_stat;
    end
  end

  // Read data captured in the setup cycle, zero otherwise
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (apb_setup && !pwrite && hit_ctrl) begin
      prdata <= ctrl_word;                        // [R17]
    end else if (apb_setup && !pwrite && hit_stat) begin
      prdata <= stat_word;
    end else begin
      prdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ==== dv/rbs_sequencer_props.sv ====
// Port-level checks for the reset and brown-out sequencer
`timescale 1ns/1ns
`default_nettype none
module rbs_sequencer_props
  import rbs_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = 16
) (
  // Clock and reset
  input wire logic      clk_sys,
  input wire logic      rst_b,
  // Watched inputs
  input wire logic      por_vdd_low,
  input wire rbs_mode_e brownout_mode_sel,
  input wire logic      brownout_level_sel,
  input wire logic      powerup_delay_enable_n,
  input wire logic      core_sleep,
  input wire logic      psel,
  input wire logic      penable,
  // Watched outputs
  input wire logic [31:0] prdata,
  input wire logic      pready,
  input wire logic      pslverr,
  input wire logic      core_rst_n,
  input wire logic      bor_detector_en,
  input wire logic      bandgap_force_on,
  input wire logic      brownout_level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Cycles since the supply came up, saturating
  int unsigned up_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) up_q <= 0;
    else if (por_vdd_low) up_q <= 0;
    else if (up_q < POWERUP_DELAY_TIMER_CYCLES) up_q <= up_q + 1;
  end

  por_hold_a: assert property (por_vdd_low |-> !core_rst_n)
    else $error("core runs while supply low");
  timer_len_a: assert property ($rose(core_rst_n) |->
    powerup_delay_enable_n || up_q >= POWERUP_DELAY_TIMER_CYCLES)
    else $error("core released before power-up delay");
  off_mode_a: assert property (brownout_mode_sel == RBS_MODE_OFF
    |=> !bor_detector_en) else $error("detector on in off mode");
  on_mode_a: assert property (rst_b && brownout_mode_sel == RBS_MODE_ON
    |=> bor_detector_en) else $error("detector off in on mode");
  sleep_off_a: assert property (brownout_mode_sel == RBS_MODE_SLEEP
    && core_sleep |=> !bor_detector_en) else $error("detector on in sleep");
  fast_start_a: assert property (brownout_mode_sel[1] ==
    brownout_mode_sel[0] |=> !bandgap_force_on)
    else $error("band gap forced in fixed mode");
  level_copy_a: assert property (1'b1 |=>
    brownout_level == $past(brownout_level_sel))
    else $error("trip level not copied");
  apb_answer_a: assert property (psel && !penable && !pready |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_qual_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");

  cover property ($rose(core_rst_n));
  cover property (pslverr);
  cover property ($fell(bor_detector_en));
endmodule

bind rbs_sequencer rbs_sequencer_props #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) i_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .por_vdd_low(por_vdd_low),
  .brownout_mode_sel(brownout_mode_sel),
  .brownout_level_sel(brownout_level_sel),
  .powerup_delay_enable_n(powerup_delay_enable_n),
  .core_sleep(core_sleep), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_rst_n(core_rst_n), .bor_detector_en(bor_detector_en),
  .bandgap_force_on(bandgap_force_on), .brownout_level(brownout_level));
`default_nettype wire

// ==== dv/rbs_sequencer_tb.sv ====
// Self-checking bench for the reset and brown-out sequencer
`timescale 1ns/1ns
`default_nettype none
module rbs_sequencer_tb;
  import rbs_pkg::*;
  localparam int POWERUP_DELAY_TIMER = 50;
  logic        clk_sys, rst_b, por, bor, rdy, pin_n, slp, lvl_sel, lvl;
  logic        psel, penable, pwrite, pready, pslverr, err, core_rst_n;
  logic        det_en, bg_on, powerup_delay_enable_n_n, wk, wg;
  logic [5:0]  src;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  rbs_mode_e   mode;
  int          bad_count, check_count, n;

  rbs_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .por_vdd_low(por),
    .bor_vdd_low(bor), .bor_det_ready(rdy), .low_power_brownout_reset_vdd_low(src[4]),
    .brownout_mode_sel(mode), .brownout_level_sel(lvl_sel),
    .powerup_delay_enable_n(powerup_delay_enable_n_n), .low_power_brownout_reset_cfg_en(1'b1),
    .ext_reset_cfg_en(1'b1), .stack_reset_cfg_en(1'b1),
    .external_reset_pin_n(pin_n), .wdt_reset_req(src[0]),
    .instr_reset_req(src[1]), .stack_overflow_req(src[2]),
    .stack_underflow_req(src[3]), .prog_mode_exit(src[5]),
    .core_sleep(slp), .wake_req(wk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_rst_n(core_rst_n),
    .wake_grant(wg), .bor_detector_en(det_en), .bandgap_force_on(bg_on),
    .brownout_level(lvl));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Counts edges until the core reset reaches the given level
  task automatic wait_rst(input logic v);
    n = 0;
    while (core_rst_n !== v && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(core_rst_n, v);
  endtask

  task automatic end_sim();
    $display("checks=%0d errors=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    end_sim();
  end

  initial begin
    {rst_b, bor, slp, lvl_sel, psel, penable, pwrite, powerup_delay_enable_n_n, wk, src} = '0;
    {por, rdy, pin_n} = 3'b111;
    paddr = '0;
    pwdata = '0;
    mode = RBS_MODE_ON;
    cyc(16);
    rst_b <= 1'b1;
    cyc(8);
    chk(core_rst_n, 1'b0);
    por <= 1'b0;
    lvl_sel <= 1'b1;
    @(posedge clk_sys);
    wait_rst(1'b1);
    chk(n >= POWERUP_DELAY_TIMER, 1'b1);
    chk(lvl, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h81);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h01);
    chk(det_en, 1'b1);
    apb(1'b1, 12'h000, 32'hff);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'hc1);
    chk(bg_on, 1'b0);
    apb(1'b1, 12'h008, 32'h1);
    chk(err, 1'b1);
    // Software mode, enable still set from the write above
    mode <= RBS_MODE_SW;
    cyc(3);
    chk(det_en, 1'b1);
    chk(bg_on, 1'b1);
    slp <= 1'b1;
    cyc(3);
    chk(det_en, 1'b1);
    apb(1'b1, 12'h000, 32'h40);
    cyc(2);
    chk(det_en, 1'b0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h40);
    mode <= RBS_MODE_SLEEP;
    rdy <= 1'b0;
    wk <= 1'b1;
    cyc(3);
    chk(det_en, 1'b0);
    chk(wg, 1'b0);
    rdy <= 1'b1;
    cyc(2);
    chk(wg, 1'b1);
    mode <= RBS_MODE_OFF;
    slp <= 1'b0;
    wk <= 1'b0;
    cyc(3);
    chk(det_en, 1'b0);
    mode <= RBS_MODE_ON;
    cyc(3);
    chk(core_rst_n, 1'b1);
    // Pin reset long after the timer expired
    pin_n <= 1'b0;
    wait_rst(1'b0);
    cyc(POWERUP_DELAY_TIMER + 10);
    pin_n <= 1'b1;
    wait_rst(1'b1);
    // Pin seen one edge late, release seen one edge after the flop
    chk(n, 10 + 2);
    // Short dip is filtered, long dip trips
    bor <= 1'b1;
    cyc(100);
    bor <= 1'b0;
    chk(core_rst_n, 1'b1);
    cyc(4);
    bor <= 1'b1;
    cyc(300);
    chk(core_rst_n, 1'b0);
    bor <= 1'b0;
    @(posedge clk_sys);
    wait_rst(1'b1);
    chk(n >= POWERUP_DELAY_TIMER, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h81);
    for (int i = 0; i < 6; i++) begin
      src[i] <= 1'b1;
      wait_rst(1'b0);
      src[i] <= 1'b0;
      wait_rst(1'b1);
    end
    // Timer bypassed: a supply restart is not held for the delay
    powerup_delay_enable_n_n <= 1'b1;
    src[5] <= 1'b1;
    wait_rst(1'b0);
    src[5] <= 1'b0;
    wait_rst(1'b1);
    chk(n < POWERUP_DELAY_TIMER, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
